// ### inc/qacsc_map.svh
// Constants of the four-channel converter serial control block.
// Assumes it is included by its bare name from the package and the design file.
`ifndef QACSC_MAP_SVH
`define QACSC_MAP_SVH
`define QACSC_DATA_W       12
`define QACSC_CMD_W        8
`define QACSC_ADDR_HI      5
`define QACSC_ADDR_LO      3
`define QACSC_SEL_HI       4
`define QACSC_CH_DEFAULT   2'h0
`define QACSC_FRAME_EDGES  5'h10
`define QACSC_CMD_EDGES    5'h08
`define QACSC_TRACK_EDGES  5'h03
`define QACSC_FIRST_OUT    5'h04
`define QACSC_FIFO_DEPTH   16
`define QACSC_FIFO_AW      4
`endif

// ### inc/qacsc_pkg.sv
// Types shared by the converter serial control block.
// Assumes the constants header is on the include path.
`include "qacsc_map.svh"
package qacsc_pkg;
    // One finished conversion: the channel sampled and its straight-binary code.
    typedef struct packed {
        logic [1:0]                 chan;
        logic [`QACSC_DATA_W-1:0]   code;
    } qacsc_sample_t;
    // Conversion phase of the serial sequence.
    typedef enum logic [1:0] {
        QACSC_SHUTDOWN,
        QACSC_TRACK,
        QACSC_CONVERT
    } qacsc_phase_t;
endpackage

// ### logic/qacsc_top.sv
// Serial control and sequencing of a four-channel 12-bit converter, with the
// sample FIFO that feeds the serial output.
// Assumes REF_CLK is far faster than the serial clock (250 MHz against 3.2 MHz or less).
`timescale 1ns/1ps
`include "qacsc_map.svh"

module qacsc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    input  wire logic             out_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count_ff < (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage needs no reset; only the pointers define contents.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointer and count bookkeeping.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // qacsc_fifo

module qacsc_top
    import qacsc_pkg::*;
(
    // Clock and reset.
    input  wire logic                     REF_CLK,
    input  wire logic                     RST_B,
    // Serial pins from the host.
    input  wire logic                     CS_B,
    input  wire logic                     SCLK,
    input  wire logic                     DIN,
    // Serial result pin, two signals.
    output logic                          DOUT_O,
    output logic                          DOUT_OE_B,
    // Analog front end: mux select, track switch, power state.
    output logic [1:0]                    MUX_SEL,
    output logic                          TRACK,
    output logic                          POWERED,
    // Converter core supplies samples here.
    input  wire logic                     SMP_VALID,
    output logic                          SMP_READY,
    input  wire logic [`QACSC_DATA_W-1:0] SMP_CODE
);
    // Three-stage synchronisers for the pins.
    logic [2:0] cs_sync_ff;
    logic [2:0] sclk_sync_ff;
    logic [2:0] din_sync_ff;
    logic       cs_b_ff;
    logic       sclk_ff;
    logic       din_ff;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_fall;
    logic       cs_low;

    // Sequencing state.
    qacsc_phase_t             phase_ff;
    logic [4:0]               rise_cnt_ff;
    logic [4:0]               fall_cnt_ff;
    logic [`QACSC_CMD_W-1:0]  cmd_ff;
    logic [1:0]               next_chan_ff;
    logic [`QACSC_DATA_W-1:0] shift_ff;
    logic                     fifo_out_valid;
    qacsc_sample_t            fifo_out;
    qacsc_sample_t            fifo_in;
    logic                     fifo_in_ready;
    logic                     take;
    logic [`QACSC_DATA_W-1:0] out_code;

    // Decode the channel from a command word.
    function automatic logic [1:0] chan_of(input logic [`QACSC_CMD_W-1:0] cmd);
        return cmd[`QACSC_SEL_HI:`QACSC_ADDR_LO];
    endfunction

    // A pin changes state only once stages two and three agree.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cs_sync_ff   <= 3'h7;
            sclk_sync_ff <= 3'h0;
            din_sync_ff  <= 3'h0;
            cs_b_ff      <= 1'b1;
            sclk_ff      <= 1'b0;
            din_ff       <= 1'b0;
        end else begin
            cs_sync_ff   <= {cs_sync_ff[1:0], CS_B};
            sclk_sync_ff <= {sclk_sync_ff[1:0], SCLK};
            din_sync_ff  <= {din_sync_ff[1:0], DIN};
            if (cs_sync_ff[1] == cs_sync_ff[2]) begin
                cs_b_ff <= cs_sync_ff[2];
            end
            if (sclk_sync_ff[1] == sclk_sync_ff[2]) begin
                sclk_ff <= sclk_sync_ff[2];
            end
            if (din_sync_ff[1] == din_sync_ff[2]) begin
                din_ff <= din_sync_ff[2];
            end
        end
    end

    // Clock is gated off while frame select is high. A fall of frame select that
    // finds the clock low, whether it fell at the same moment or was parked low,
    // registers as a falling clock edge, so the next rise is edge one.
    assign cs_low    = !cs_b_ff;
    assign cs_fall   = cs_b_ff && (cs_sync_ff[2:1] == 2'h0);
    assign sclk_rise = cs_low && !sclk_ff && (sclk_sync_ff[2:1] == 2'h3);
    assign sclk_fall = (cs_low && sclk_ff && (sclk_sync_ff[2:1] == 2'h0))
                     || (cs_fall && (sclk_sync_ff[2:1] == 2'h0));

    // Edge counters within one 16-clock conversion; they wrap for back to back runs.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rise_cnt_ff <= 5'h00;
            fall_cnt_ff <= 5'h00;
        end else if (!cs_low && !cs_fall) begin
            rise_cnt_ff <= 5'h00;
            fall_cnt_ff <= 5'h00;
        end else begin
            if (sclk_rise) begin
                rise_cnt_ff <= (rise_cnt_ff == `QACSC_FRAME_EDGES - 5'h01) ? 5'h00 : rise_cnt_ff + 5'h01;
            end
            if (sclk_fall) begin
                fall_cnt_ff <= (fall_cnt_ff == `QACSC_FRAME_EDGES) ? 5'h01 : fall_cnt_ff + 5'h01;
            end
        end
    end

    // Command shift on the first eight rising edges, MSB first.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_ff       <= 8'h00;
            next_chan_ff <= `QACSC_CH_DEFAULT;
        end else if (sclk_rise && rise_cnt_ff < `QACSC_CMD_EDGES) begin
            cmd_ff <= {cmd_ff[`QACSC_CMD_W-2:0], din_ff};
            if (rise_cnt_ff == `QACSC_CMD_EDGES - 5'h01) begin
                next_chan_ff <= chan_of({cmd_ff[`QACSC_CMD_W-2:0], din_ff});
            end
        end
    end

    // Phase: track from the first falling edge for three clocks, then convert
    // until the sixteenth falling edge, then power down until the next fall.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_ff <= QACSC_SHUTDOWN;
        end else if (!cs_low && !cs_fall) begin
            phase_ff <= QACSC_SHUTDOWN;
        end else if (sclk_fall) begin
            unique case (fall_cnt_ff)
                `QACSC_FRAME_EDGES - 5'h01: phase_ff <= QACSC_SHUTDOWN;
                `QACSC_FRAME_EDGES, 5'h00: phase_ff <= QACSC_TRACK;
                `QACSC_TRACK_EDGES: phase_ff <= QACSC_CONVERT;
                default: phase_ff <= phase_ff;
            endcase
        end
    end

    // The mux takes the latest command's channel only at the first falling edge, as tracking starts.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            MUX_SEL <= `QACSC_CH_DEFAULT;
            TRACK   <= 1'b0;
            POWERED <= 1'b0;
        end else begin
            TRACK   <= (phase_ff == QACSC_TRACK);
            POWERED <= (phase_ff != QACSC_SHUTDOWN);
            if (sclk_fall && (fall_cnt_ff == `QACSC_FRAME_EDGES || fall_cnt_ff == 5'h00)) begin
                MUX_SEL <= next_chan_ff;
            end
        end
    end

    // Result shifting: load at the fifth falling edge, so the MSB stands before the
    // fifth rise, and shift MSB first on every later fall of the conversion.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            shift_ff  <= 12'h000;
            DOUT_O    <= 1'b0;
            DOUT_OE_B <= 1'b1;
        end else begin
            DOUT_OE_B <= cs_b_ff;
            if (!cs_low) begin
                DOUT_O <= 1'b0;
            end else if (sclk_fall) begin
                if (fall_cnt_ff == `QACSC_FIRST_OUT) begin
                    DOUT_O   <= out_code[`QACSC_DATA_W-1];
                    shift_ff <= {out_code[`QACSC_DATA_W-2:0], 1'b0};
                end else if (fall_cnt_ff > `QACSC_FIRST_OUT) begin
                    DOUT_O   <= shift_ff[`QACSC_DATA_W-1];
                    shift_ff <= {shift_ff[`QACSC_DATA_W-2:0], 1'b0};
                end else begin
                    DOUT_O <= 1'b0;
                end
            end
        end
    end

    // A sample is taken from the FIFO when the result starts to shift out; an
    // empty FIFO gives zeros rather than stalling the host's fixed timing.
    assign take         = sclk_fall && (fall_cnt_ff == `QACSC_FIRST_OUT) && fifo_out_valid;
    assign out_code     = fifo_out_valid ? fifo_out.code : '0;
    assign fifo_in.chan = MUX_SEL;
    assign fifo_in.code = SMP_CODE;

    // The ready toward the core is registered so that the output rule holds. It
    // drops for one cycle after each accepted sample, because that sample may have
    // filled the buffer; so it never promises room that is not there.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SMP_READY <= 1'b0;
        end else begin
            SMP_READY <= fifo_in_ready && !(SMP_VALID && SMP_READY);
        end
    end

    qacsc_fifo #(
        .WIDTH ($bits(qacsc_sample_t)),
        .DEPTH (`QACSC_FIFO_DEPTH),
        .AW    (`QACSC_FIFO_AW)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .in_valid  (SMP_VALID && SMP_READY && fifo_in_ready),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_ready (take),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out)
    );

    // Assertions.
    a_outen_follow_cs: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        ##1 (DOUT_OE_B == $past(cs_b_ff)))
        else $error("Output enable does not follow frame select.");
    a_shutdown_high_cs: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !cs_low && !cs_fall |=> phase_ff == QACSC_SHUTDOWN)
        else $error("Not powered down with frame select high.");
    a_cnt_bound: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        rise_cnt_ff < `QACSC_FRAME_EDGES)
        else $error("Rising edge count exceeds sixteen.");
    a_pdown_at16: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        sclk_fall && fall_cnt_ff == 5'h0F |=> phase_ff == QACSC_SHUTDOWN)
        else $error("No power down at edge 16.");
    a_track_at1: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        sclk_fall && fall_cnt_ff == 5'h00 |=> phase_ff == QACSC_TRACK)
        else $error("No track at first fall.");
    a_convert_at4: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        sclk_fall && fall_cnt_ff == 5'h03 |=> phase_ff == QACSC_CONVERT)
        else $error("No convert at fourth fall.");
    a_chan_decode: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        sclk_rise && rise_cnt_ff == 5'h07 |=> next_chan_ff == $past(cmd_ff[3:2]))
        else $error("Bad channel decode.");
    a_cnt_reset: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !cs_low && !cs_fall |=> rise_cnt_ff == 5'h00 && fall_cnt_ff == 5'h00)
        else $error("Counters not cleared.");
    a_joint_fall_track: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        cs_fall && sclk_sync_ff[2:1] == 2'h0 |=> fall_cnt_ff == 5'h01 && phase_ff == QACSC_TRACK)
        else $error("Clock low at frame start not counted as first fall.");
    a_ready_has_room: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        SMP_READY |-> fifo_in_ready)
        else $error("Sample ready raised while the buffer is full.");
endmodule // qacsc_top

// ### test/qacsc_host.sv
// Host serial controller model that frames conversions for the converter block.
// Assumes the bench calls its tasks and keeps every frame a whole number of conversions.
`timescale 1ns/1ps
module qacsc_host (
    // Serial pins towards the block.
    output logic      CS_B,
    output logic      SCLK,
    output logic      DIN,
    // Serial result from the block.
    input  wire logic DOUT_O,
    input  wire logic DOUT_OE_B
);
    // Half of a 48 ns link period. This is faster than the slow-clock ceiling
    // the host may choose for low power; it keeps the run short, and the block
    // only needs a few reference clocks per half period.
    localparam realtime HALF = 24.0;
    // The clock is parked high between frames so no stray edge reaches the block.
    initial begin
        CS_B = 1'b1;
        SCLK = 1'b1;
        DIN  = 1'b0;
    end
    // Opens a frame. With low_idle the clock and frame select fall together;
    // otherwise the clock stays high for half a period after frame select falls.
    // Pins change by non-blocking assignment so they never race the sampling edge.
    task automatic frame_start(input logic low_idle);
        #HALF;
        if (low_idle) begin
            SCLK <= 1'b0;
        end
        CS_B <= 1'b0;
        if (!low_idle) begin
            #HALF;
        end
    endtask
    // Closes a frame after the last rising edge and lets the link rest.
    task automatic frame_end();
        #HALF;
        CS_B <= 1'b1;
        #(4 * HALF);
    endtask
    // One conversion of exactly 16 clocks: command out, result in.
    task automatic convert(input logic [7:0] cmd, input logic skip, output logic [11:0] res);
        res = 12'h000;
        for (int i = 1; i <= 16; i++) begin
            if (!(skip && i == 1)) begin
                SCLK <= 1'b0;
            end
            // Past the command the data line keeps toggling so no stale bit is mistaken for one.
            DIN <= (i <= 8) ? cmd[8-i] : ~DIN;
            #HALF;
            SCLK <= 1'b1;
            if (i >= 5) begin
                res = {res[10:0], DOUT_OE_B ? ~res[0] : DOUT_O};
            end
            #HALF;
        end
    endtask
endmodule // qacsc_host

// ### test/test_qacsc_top.sv
// Self-checking bench of the converter serial control block.
// Assumes the host model drives the link and the bench plays the converter core.
`timescale 1ns/1ps
module test_qacsc_top;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [11:0] code;
    } qacsc_row_t;
    logic        ref_clk;
    logic        rst_b;
    logic        cs_b;
    logic        sclk;
    logic        din;
    logic        dout_o;
    logic        dout_oe_b;
    logic [1:0]  mux_sel;
    logic        track;
    logic        powered;
    logic        smp_valid;
    logic        smp_ready;
    logic [11:0] smp_code;
    logic [11:0] res;
    logic [1:0]  prev_chan;
    logic [1:0]  mux_q[$];
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;
    qacsc_row_t  rows[6] = '{'{8'h08, 12'hFFF}, '{8'hF7, 12'h000}, '{8'h27, 12'hA5A},
                             '{8'hC8, 12'h5A5}, '{8'h00, 12'h001}, '{8'h18, 12'h800}};
    qacsc_top qacsc_top_i (.REF_CLK(ref_clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .DIN(din),
        .DOUT_O(dout_o), .DOUT_OE_B(dout_oe_b), .MUX_SEL(mux_sel), .TRACK(track), .POWERED(powered),
        .SMP_VALID(smp_valid), .SMP_READY(smp_ready), .SMP_CODE(smp_code));
    qacsc_host qacsc_host_i (.CS_B(cs_b), .SCLK(sclk), .DIN(din), .DOUT_O(dout_o), .DOUT_OE_B(dout_oe_b));
    // Reference clock at 250 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Compares one value and counts it.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hands one code to the block, held until it is taken.
    task automatic push(input logic [11:0] c);
        int n;
        n = 0;
        @(posedge ref_clk);
        smp_valid <= 1'b1;
        smp_code  <= c;
        @(posedge ref_clk);
        while (smp_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 50) check("sample taken", 16'h0, 16'h1);
        smp_valid <= 1'b0;
    endtask
    // The mux is read as tracking ends, when the channel is surely settled.
    always @(negedge track) begin
        if (rst_b === 1'b1) begin
            mux_q.push_back(mux_sel);
            check("powered in track", powered, 1);
        end
    end
    // One conversion with its result and channel compared.
    task automatic run(input logic [7:0] cmd, input logic [11:0] code, input logic skip);
        qacsc_host_i.convert(cmd, skip, res);
        check("result", res, code);
        if (mux_q.size() == 0) check("track seen", 16'h0, 16'h1);
        else check("channel", mux_q.pop_front(), prev_chan);
        prev_chan = cmd[4:3];
    endtask
    // Hang guard, sized well beyond the planned run.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        rst_b = 1'b0;
        smp_valid = 1'b0;
        smp_code = 12'h000;
        prev_chan = 2'h0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("idle oe", dout_oe_b, 1);
        check("idle power", powered, 0);
        // Ordinary cases: back to back conversions in one frame.
        foreach (rows[i]) push(rows[i].code);
        qacsc_host_i.frame_start(1'b0);
        foreach (rows[i]) run(rows[i].cmd, rows[i].code, 1'b0);
        #20;
        check("power between", powered, 0);
        check("frame oe", dout_oe_b, 0);
        qacsc_host_i.frame_end();
        check("released oe", dout_oe_b, 1);
        check("frame power", powered, 0);
        // Frame select and clock falling together.
        push(12'h3C3);
        qacsc_host_i.frame_start(1'b1);
        run(8'hFF, 12'h3C3, 1'b1);
        qacsc_host_i.frame_end();
        // Fill the buffer until it refuses, then drain it past empty.
        for (int i = 0; i < 16; i++) push(12'h100 + 12'(i));
        @(posedge ref_clk);
        smp_valid <= 1'b1;
        smp_code  <= 12'hEEE;
        repeat (3) @(posedge ref_clk);
        check("full ready", smp_ready, 0);
        smp_valid <= 1'b0;
        qacsc_host_i.frame_start(1'b0);
        for (int i = 0; i < 17; i++) run(8'h10, (i < 16) ? 12'h100 + 12'(i) : 12'h000, 1'b0);
        qacsc_host_i.frame_end();
        // Reset between frames: the channel stored by the last command must be forgotten.
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("reset oe", dout_oe_b, 1);
        check("reset dout", dout_o, 0);
        check("reset mux", mux_sel, 0);
        check("reset power", powered, 0);
        check("reset track", track, 0);
        check("reset ready", smp_ready, 0);
        rst_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("ready after reset", smp_ready, 1);
        prev_chan = 2'h0;
        qacsc_host_i.frame_start(1'b0);
        run(8'h3F, 12'h000, 1'b0);
        qacsc_host_i.frame_end();
        finish_test();
    end
endmodule // test_qacsc_top
